// ===== rtl/plm_map.svh
`ifndef PLM_MAP_SVH
`define PLM_MAP_SVH

// ----------------------------------------
// fabric sizes
// ----------------------------------------
`define PLM_BLOCKS       4
`define PLM_CELLS        36
`define PLM_PER_BLK      9
`define PLM_XB_PER_BLK   21
`define PLM_XB_OUTS      84
`define PLM_SOURCES      68
`define PLM_PIN_CELLS    34
`define PLM_INPUTS       32
`define PLM_TERMS        57
`define PLM_PRIV         5
`define PLM_SHARED_BASE  45
`define PLM_FAST_BLOCKS  3
`define PLM_DEC_N        4
`define PLM_CMP_N        2

// ----------------------------------------
// register word indices (byte address = 4 * index)
// ----------------------------------------
`define PLM_TERM_BASE    11'h000
`define PLM_XBAR_BASE    11'h200
`define PLM_CELL_BASE    11'h400
`define PLM_INCFG_BASE   11'h440
`define PLM_DEC_BASE     11'h460
`define PLM_CMP_BASE     11'h464
`define PLM_CFG_WORDS    11'h466
`define PLM_GLOBAL_IDX   11'h466
`define PLM_STATUS_IDX   11'h467

// ----------------------------------------
// cell word fields
// ----------------------------------------
`define PLM_C_SHA_LSB    0
`define PLM_C_SHB_LSB    4
`define PLM_C_TOGGLE     12
`define PLM_C_CTRL       13
`define PLM_C_LUT_LSB    14
`define PLM_C_ARITH      18
`define PLM_C_SUB        19
`define PLM_C_TRANSP     20
`define PLM_C_CLK_LSB    21
`define PLM_C_PRELOAD    23
`define PLM_C_OE_FB      24
`define PLM_C_OE_LSB     25
`define PLM_C_INV        27

// input word: mode [1:0], alternate clock bit
`define PLM_I_CLK_ALT    2
// decoder / comparator words
`define PLM_D_CARE_LSB   8
`define PLM_D_POL        16
`define PLM_K_GATE_LSB   16
`define PLM_K_OFF        20
`define PLM_K_POL        21
// global word fields
`define PLM_G_ALT_CLK    0
`define PLM_G_CIN_ONE    1
`define PLM_G_SECURE     2

// ----------------------------------------
// timing
// ----------------------------------------
`define PLM_CLK_PERIOD_NS     100
`define PLM_CONFIG_PERIOD_NS  350000
`define PLM_CONFIG_CYCLES     (`PLM_CONFIG_PERIOD_NS / `PLM_CLK_PERIOD_NS)

`endif

// ===== rtl/plm_pkg.sv
package plm_pkg;
`include "plm_map.svh"

typedef enum logic [1:0] {
    PLM_IN_DIRECT = 2'h0,
    PLM_IN_LATCH  = 2'h1,
    PLM_IN_REG    = 2'h2
} plm_inmode_t;

typedef enum logic [1:0] {
    PLM_CK_TERM = 2'h0,
    PLM_CK_A    = 2'h1,
    PLM_CK_B    = 2'h2
} plm_clksel_t;

typedef enum logic [1:0] {
    PLM_OE_OFF    = 2'h0,
    PLM_OE_TERM   = 2'h1,
    PLM_OE_SHARED = 2'h2,
    PLM_OE_BOTH   = 2'h3
} plm_oemode_t;

typedef enum logic {
    PLM_ST_CONFIG = 1'b0,
    PLM_ST_RUN    = 1'b1
} plm_phase_t;

typedef struct packed {
    logic [29:0] io_in;
    logic [1:0]  ded_in;
    logic [2:0]  fast_input_pin;
    logic [2:0]  global_clock_in;
    logic        shared_output_enable;
    logic        master_reset_pin;
    logic [5:0]  decoder_inputs;
    logic [5:0]  comparator_inputs;
    logic        comparator_load;
} plm_pin_in_t;

typedef struct packed {
    plm_pin_in_t s1;
    plm_pin_in_t s2;
    logic [2:0]  gprev;
    logic [31:0] in_q;
    logic [35:0] q;
    logic [35:0] ptc_prev;
    logic [33:0] pin_out;
    logic [33:0] pin_oe;
    logic [3:0]  dec_out;
    logic [1:0]  cmp_out;
    logic [11:0] cmp_pat;
    logic [11:0] cfg_cnt;
    plm_phase_t  phase;
    logic        secure;
    logic        alt_clk;
    logic        cin_one;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
} plm_state_t;

endpackage

// ===== rtl/plm_fabric.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "plm_map.svh"
module plm_fabric (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire plm_pkg::plm_pin_in_t pin_in,
    output logic      [33:0]         mc_pin,
    output logic      [33:0]         mc_pin_oe,
    output logic      [3:0]          decoder_output,
    output logic      [1:0]          comparator_output
);

    plm_pkg::plm_state_t r;
    plm_pkg::plm_state_t next_r;
    logic [31:0] cfg_mem [`PLM_CFG_WORDS];

    logic [`PLM_SOURCES-1:0] xsrc;
    logic [`PLM_XB_OUTS-1:0] xout;
    logic [`PLM_CELLS-1:0]   fb, dval, opa, opb, ptclk, ptrst, ptset;
    logic [`PLM_CELLS-1:0]   cedge, cpre, ctr, pinv, poe;
    logic [`PLM_CELLS:0]     carry;
    logic [`PLM_INPUTS-1:0]  in_val, in_nxt, raw32;
    logic [2:0]              grise;
    logic [3:0]              dmatch, dnxt;
    logic [1:0]              knxt;
    logic [11:0]             kpat_nxt;
    logic [10:0]             idx;
    logic                    hit, busy, wr;

    assign busy  = (r.phase == plm_pkg::PLM_ST_CONFIG);
    assign grise = r.s2.global_clock_in & ~r.gprev;
    assign raw32 = {r.s2.ded_in, r.s2.io_in};
    assign idx   = paddr[12:2];
    assign hit   = (paddr[31:13] == 19'h0) && (idx <= `PLM_STATUS_IDX);
    assign wr    = psel & penable & r.pready & pwrite & ~r.pslverr;
    assign carry[0] = r.cin_one;

    // ----------------------------------------
    // input pins
    // ----------------------------------------
    for (genvar i = 0; i < `PLM_INPUTS; i++)
    begin : g_in
        logic [31:0]          w;
        logic [1:0]           ci;
        logic                 lvl;
        plm_pkg::plm_inmode_t md;
        assign w   = cfg_mem[`PLM_INCFG_BASE + i];
        assign md  = plm_pkg::plm_inmode_t'(w[1:0]);
        assign ci  = w[`PLM_I_CLK_ALT] ? (r.alt_clk ? 2'h2 : 2'h1) : 2'h0;
        assign lvl = r.s2.global_clock_in[ci];
        // latch follows while clock high, register takes rising edge
        assign in_val[i] = (md == plm_pkg::PLM_IN_LATCH) ? (lvl ? raw32[i] : r.in_q[i])
                         : (md == plm_pkg::PLM_IN_REG) ? r.in_q[i] : raw32[i];
        assign in_nxt[i] = (((md == plm_pkg::PLM_IN_LATCH) && lvl)
                         || ((md == plm_pkg::PLM_IN_REG) && grise[ci]))
                         ? raw32[i] : r.in_q[i];
    end

    // ----------------------------------------
    // crossbar
    // ----------------------------------------
    assign xsrc = {in_val, fb};
    for (genvar j = 0; j < `PLM_XB_OUTS; j++)
    begin : g_xbar
        localparam int W = `PLM_XBAR_BASE + 4 * j;
        logic [`PLM_SOURCES-1:0] msk;
        assign msk     = {cfg_mem[W + 2][3:0], cfg_mem[W + 1], cfg_mem[W]};
        // unconnected output idles high
        assign xout[j] = &(xsrc | ~msk);
    end

    // ----------------------------------------
    // logic blocks and cells
    // ----------------------------------------
    for (genvar b = 0; b < `PLM_BLOCKS; b++)
    begin : g_blk
        logic [23:0]             in24;
        logic [47:0]             lit;
        logic [`PLM_TERMS-1:0]   pt;
        logic [2:0]              fin;
        assign fin  = (b < `PLM_FAST_BLOCKS) ? r.s2.fast_input_pin : 3'h0;
        assign in24 = {fin, xout[b*`PLM_XB_PER_BLK +: `PLM_XB_PER_BLK]};
        assign lit  = {~in24, in24};
        for (genvar t = 0; t < `PLM_TERMS; t++)
        begin : g_term
            localparam int W = `PLM_TERM_BASE + 2 * (64 * b + t);
            assign pt[t] = &(lit | ~{cfg_mem[W + 1][23:0], cfg_mem[W][23:0]});
        end
        for (genvar k = 0; k < `PLM_PER_BLK; k++)
        begin : g_cell
            localparam int M = b * `PLM_PER_BLK + k;
            logic [31:0]             cw;
            logic [4:0]              pv;
            logic [11:0]             sh;
            logic [3:0]              lut;
            logic                    ctl, toe, bx, so;
            plm_pkg::plm_clksel_t    cs;
            plm_pkg::plm_oemode_t    om;
            assign cw  = cfg_mem[`PLM_CELL_BASE + M];
            assign pv  = pt[`PLM_PRIV*k +: `PLM_PRIV];
            assign sh  = pt[`PLM_SHARED_BASE +: 12];
            assign ctl = cw[`PLM_C_CTRL];
            assign lut = cw[`PLM_C_LUT_LSB +: 4];
            assign cs  = plm_pkg::plm_clksel_t'(cw[`PLM_C_CLK_LSB +: 2]);
            assign om  = plm_pkg::plm_oemode_t'(cw[`PLM_C_OE_LSB +: 2]);
            assign so  = r.s2.shared_output_enable;
            // control mode takes four private terms away from logic
            assign ptclk[M] = ctl & pv[0];
            assign ptrst[M] = ctl & pv[1];
            assign ptset[M] = ctl & pv[2];
            assign toe      = ctl ? pv[3] : 1'b1;
            assign opa[M] = (~ctl & |pv[3:0])
                          | |(sh[3:0] & cw[`PLM_C_SHA_LSB +: 4]);
            assign opb[M] = pv[4] | |(sh[11:4] & cw[`PLM_C_SHB_LSB +: 8])
                          | (cw[`PLM_C_TOGGLE] & r.q[M] & &sh[2:0]);
            assign bx = opb[M] ^ cw[`PLM_C_SUB];
            assign carry[M+1] = (opa[M] & bx) | (carry[M] & (opa[M] ^ bx));
            assign dval[M] = cw[`PLM_C_ARITH] ? (opa[M] ^ bx ^ carry[M])
                           : lut[{opb[M], opa[M]}];
            assign cedge[M] = (cs == plm_pkg::PLM_CK_A) ? grise[0]
                            : (cs == plm_pkg::PLM_CK_B) ? grise[1]
                            : (ptclk[M] & ~r.ptc_prev[M]);
            assign ctr[M]  = cw[`PLM_C_TRANSP];
            assign cpre[M] = cw[`PLM_C_PRELOAD];
            assign fb[M]   = (cw[`PLM_C_OE_FB] & ~toe) | r.q[M];
            assign pinv[M] = r.q[M] ^ cw[`PLM_C_INV];
            assign poe[M]  = (om == plm_pkg::PLM_OE_TERM) ? toe
                           : (om == plm_pkg::PLM_OE_SHARED) ? so
                           : (om == plm_pkg::PLM_OE_BOTH) ? (toe & so) : 1'b0;
        end
    end

    // ----------------------------------------
    // decoders and comparators
    // ----------------------------------------
    for (genvar d = 0; d < `PLM_DEC_N; d++)
    begin : g_dec
        logic [31:0] w;
        assign w = cfg_mem[`PLM_DEC_BASE + d];
        assign dmatch[d] = &((r.s2.decoder_inputs ~^ w[5:0])
                         | ~w[`PLM_D_CARE_LSB +: 6]);
        assign dnxt[d] = dmatch[d] ~^ w[`PLM_D_POL];
    end
    for (genvar c = 0; c < `PLM_CMP_N; c++)
    begin : g_cmp
        logic [31:0] w;
        logic [5:0]  pat;
        logic        eq;
        assign w   = cfg_mem[`PLM_CMP_BASE + c];
        assign pat = r.cmp_pat[6*c +: 6];
        assign eq  = &((r.s2.comparator_inputs ~^ pat) | ~w[`PLM_D_CARE_LSB +: 6])
                   & &(dmatch | ~w[`PLM_K_GATE_LSB +: 4])
                   & ~w[`PLM_K_OFF];
        assign knxt[c] = eq ~^ w[`PLM_K_POL];
        assign kpat_nxt[6*c +: 6] = busy ? w[5:0]
                                  : r.s2.comparator_load ? r.s2.comparator_inputs
                                  : pat;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.s1 = pin_in;
        next_r.s2 = r.s1;
        next_r.gprev = r.s2.global_clock_in;
        next_r.in_q = in_nxt;
        next_r.ptc_prev = ptclk;
        next_r.cmp_pat = kpat_nxt;
        next_r.dec_out = dnxt;
        next_r.cmp_out = knxt;
        next_r.pin_out = pinv[`PLM_PIN_CELLS-1:0];
        next_r.pin_oe = busy ? '0 : poe[`PLM_PIN_CELLS-1:0];
        unique case (r.phase)
            plm_pkg::PLM_ST_CONFIG:
            begin
                if (r.cfg_cnt == 12'(`PLM_CONFIG_CYCLES - 1))
                begin
                    next_r.phase = plm_pkg::PLM_ST_RUN;
                end
                else
                begin
                    next_r.cfg_cnt = r.cfg_cnt + 12'h001;
                end
            end
            plm_pkg::PLM_ST_RUN:
            begin
                next_r.phase = plm_pkg::PLM_ST_RUN;
            end
        endcase
        if (r.s2.master_reset_pin)
        begin
            next_r.phase = plm_pkg::PLM_ST_CONFIG;
            next_r.cfg_cnt = 12'h000;
        end
        for (int m = 0; m < `PLM_CELLS; m++)
        begin
            if (busy)
            begin
                next_r.q[m] = cpre[m];
            end
            else if (ptrst[m])
            begin
                next_r.q[m] = 1'b0;
            end
            else if (ptset[m])
            begin
                next_r.q[m] = 1'b1;
            end
            else if (ctr[m] || cedge[m])
            begin
                next_r.q[m] = dval[m];
            end
        end
        // register bus: answer one cycle after setup
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        if (psel && !penable)
        begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0;
            if (!hit)
            begin
                next_r.pslverr = 1'b1;
            end
            else if (idx < `PLM_CFG_WORDS)
            begin
                if (!pwrite && r.secure)
                begin
                    next_r.pslverr = 1'b1;
                end
                else if (!pwrite)
                begin
                    next_r.prdata = cfg_mem[idx];
                end
            end
            else if (idx == `PLM_GLOBAL_IDX)
            begin
                next_r.prdata = {29'h0, r.secure, r.cin_one, r.alt_clk};
            end
            else
            begin
                next_r.prdata = {30'h0, r.secure, busy};
            end
        end
        if (wr && hit && (idx == `PLM_GLOBAL_IDX))
        begin
            next_r.alt_clk = pwdata[`PLM_G_ALT_CLK];
            next_r.cin_one = pwdata[`PLM_G_CIN_ONE];
            // once set, stays set until reset
            next_r.secure = r.secure | pwdata[`PLM_G_SECURE];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int n = 0; n < `PLM_CFG_WORDS; n++)
            begin
                cfg_mem[n] <= 32'h0;
            end
        end
        else if (wr && hit && (idx < `PLM_CFG_WORDS))
        begin
            cfg_mem[idx] <= pwdata;
        end
    end

    assign prdata            = r.prdata;
    assign pready            = r.pready;
    assign pslverr           = r.pslverr;
    assign mc_pin            = r.pin_out;
    assign mc_pin_oe         = r.pin_oe;
    assign decoder_output    = r.dec_out;
    assign comparator_output = r.cmp_out;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    a_apb_answer_once: assert property (s_setup |=> s_answer)
        else $error("answer not a single cycle after setup");
    a_cfg_outs_off: assert property (busy |=> mc_pin_oe == 34'h0)
        else $error("pin enabled during configuration");
    a_cfg_period_end: assert property (
        $rose(r.phase == plm_pkg::PLM_ST_RUN) |-> $past(r.cfg_cnt) == 12'hDAB)
        else $error("configuration period wrong length");
    a_secure_no_read: assert property (
        s_setup and (r.secure && !pwrite && hit && idx < `PLM_CFG_WORDS)
        |=> pslverr && prdata == 32'h0)
        else $error("readback while secured");
    a_reset_over_set: assert property (
        !busy && ptrst[0] && ptset[0] |=> r.q[0] == 1'b0)
        else $error("set won over reset");
    a_preload_taken: assert property (busy |=> r.q[0] == $past(cpre[0]))
        else $error("preload not loaded");
    a_hold_no_edge: assert property (
        !busy && !ptrst[0] && !ptset[0] && !ctr[0] && !cedge[0] |=> $stable(r.q[0]))
        else $error("cell changed without clock");
    a_decode_match: assert property (
        ##1 decoder_output[0] == $past(dmatch[0] ~^ cfg_mem[`PLM_DEC_BASE][`PLM_D_POL]))
        else $error("decoder output wrong");
    a_cmp_forced_off: assert property (
        cfg_mem[`PLM_CMP_BASE + 1][`PLM_K_OFF]
        |=> comparator_output[1] == ~$past(cfg_mem[`PLM_CMP_BASE + 1][`PLM_K_POL]))
        else $error("disabled comparator matched");
    a_cmp_preload: assert property (
        busy |=> r.cmp_pat[5:0] == $past(cfg_mem[`PLM_CMP_BASE][5:0]))
        else $error("comparator preload not taken");
    a_cfg_restart: assert property (r.s2.master_reset_pin |=> busy)
        else $error("master reset did not restart configuration");
    a_set_alone: assert property (
        !busy && !ptrst[0] && ptset[0] |=> r.q[0])
        else $error("set did not take");
    a_edge_capture: assert property (
        !busy && !ptrst[0] && !ptset[0] && cedge[0] |=> r.q[0] == $past(dval[0]))
        else $error("clock edge did not capture");
    a_secure_sticky: assert property (r.secure |=> r.secure)
        else $error("secure bit cleared");

endmodule // plm_fabric

// ===== tb/plm_board.sv
`timescale 1ns/100ps
// ----------------------------------------
// board at the pins
// ----------------------------------------
module plm_board (
    input  wire plm_pkg::plm_pin_in_t drive,
    input  wire logic [33:0]          mc_pin,
    input  wire logic [33:0]          mc_pin_oe,
    output plm_pkg::plm_pin_in_t      pin_in
);
    // the device owns an i/o wire while it drives it
    always_comb
    begin
        pin_in = drive;
        for (int i = 0; i < 30; i++)
        begin
            if (mc_pin_oe[i])
                pin_in.io_in[i] = mc_pin[i];
        end
    end
endmodule // plm_board

// ===== tb/tb_plm_fabric.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_plm_fabric;
    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [31:0]          paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    plm_pkg::plm_pin_in_t drive;
    plm_pkg::plm_pin_in_t pin_in;
    logic [33:0]          mc_pin;
    logic [33:0]          mc_pin_oe;
    logic [3:0]           decoder_output;
    logic [1:0]           comparator_output;
    logic [31:0]          rd;
    logic                 err;
    int                   bad_count = 0;
    int                   n_tests = 0;
    int                   cycles = 0;

    plm_fabric plm_fabric_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .mc_pin(mc_pin),
        .mc_pin_oe(mc_pin_oe), .decoder_output(decoder_output),
        .comparator_output(comparator_output)
    );

    plm_board plm_board_inst (
        .drive(drive), .mc_pin(mc_pin), .mc_pin_oe(mc_pin_oe), .pin_in(pin_in)
    );

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task wrap_up;
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ----------------------------------------
    // bus master
    // ----------------------------------------
    task apb(input logic wr, input logic [10:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {19'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            bad_count++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task cfg_phase;
        apb(1'b1, 11'h400, 32'h04A0_0000);
        apb(1'b1, 11'h401, 32'h0C20_0000);
        apb(1'b0, 11'h467, 32'h0);
        `CHK(rd[0], 1'b1)
        `CHK(mc_pin_oe, 34'h0)
        while (rd[0] === 1'b1)
            apb(1'b0, 11'h467, 32'h0);
        tick(3);
        `CHK(mc_pin[1:0], 2'b11)
        `CHK(mc_pin_oe, 34'h3)
        drive.shared_output_enable <= 1'b0;
        tick(4);
        `CHK(mc_pin_oe, 34'h0)
    endtask

    // cell 0 clocked by global clock a, operands from io10 / io11
    task cell_run(input logic [31:0] cw, input logic [3:0] expv);
        apb(1'b1, 11'h400, cw);
        for (int i = 0; i < 4; i++)
        begin
            drive.io_in[11:10] <= 2'(i);
            tick(3);
            drive.global_clock_in[0] <= 1'b1;
            tick(5);
            drive.global_clock_in[0] <= 1'b0;
            tick(1);
            `CHK(mc_pin[0], expv[i])
        end
    endtask

    task alu_modes;
        apb(1'b1, 11'h000, 32'h1);
        for (int t = 1; t < 4; t++)
        begin
            apb(1'b1, 11'(2 * t), 32'h1);
            apb(1'b1, 11'(2 * t + 1), 32'h1);
        end
        apb(1'b1, 11'h008, 32'h2);
        apb(1'b1, 11'h201, 32'h0000_4000);
        apb(1'b1, 11'h205, 32'h0000_8000);
        cell_run(32'h0021_8000, 4'h6);
        cell_run(32'h0022_0000, 4'h8);
        cell_run(32'h0024_0000, 4'h6);
        apb(1'b1, 11'h466, 32'h2);
        cell_run(32'h0024_0000, 4'h9);
        cell_run(32'h002C_0000, 4'h6);
        apb(1'b1, 11'h201, 32'h0000_C000);
        cell_run(32'h0022_8000, 4'h8);
    endtask

    task decode;
        logic [5:0] vin [3];
        logic [3:0] vexp [3];
        vin = '{6'h2A, 6'h1A, 6'h00};
        vexp = '{4'h1, 4'h0, 4'h2};
        apb(1'b1, 11'h460, 32'h0001_3F2A);
        apb(1'b1, 11'h461, 32'h0000_0F2A);
        for (int i = 0; i < 3; i++)
        begin
            drive.decoder_inputs <= vin[i];
            tick(5);
            `CHK(decoder_output, vexp[i])
        end
    endtask

    task compare;
        apb(1'b1, 11'h464, 32'h0020_3F00);
        apb(1'b1, 11'h465, 32'h0030_3F00);
        drive.comparator_inputs <= 6'h15;
        drive.comparator_load <= 1'b1;
        tick(5);
        `CHK(comparator_output, 2'b01)
        drive.comparator_load <= 1'b0;
        tick(3);
        drive.comparator_inputs <= 6'h16;
        tick(5);
        `CHK(comparator_output, 2'b00)
        drive.comparator_inputs <= 6'h15;
        tick(5);
        `CHK(comparator_output, 2'b01)
        apb(1'b1, 11'h464, 32'h0021_3F00);
        tick(5);
        `CHK(comparator_output, 2'b00)
    endtask

    // cell 0 control mode: io10 clock, io8 reset, io9 set, io11 data
    task ctrl_cell;
        apb(1'b1, 11'h002, 32'h4);
        apb(1'b1, 11'h003, 32'h0);
        apb(1'b1, 11'h004, 32'h8);
        apb(1'b1, 11'h005, 32'h0);
        apb(1'b1, 11'h201, 32'h0000_4000);
        apb(1'b1, 11'h209, 32'h0000_1000);
        apb(1'b1, 11'h20D, 32'h0000_2000);
        drive.io_in[11:8] <= 4'h9;
        apb(1'b1, 11'h400, 32'h0003_2000);
        tick(6);
        `CHK(mc_pin[0], 1'b0)
        drive.io_in[8] <= 1'b0;
        tick(3);
        drive.io_in[10] <= 1'b1;
        tick(6);
        `CHK(mc_pin[0], 1'b1)
        drive.io_in[9:8] <= 2'b11;
        tick(6);
        `CHK(mc_pin[0], 1'b0)
        drive.io_in[8] <= 1'b0;
        tick(6);
        `CHK(mc_pin[0], 1'b1)
        drive.io_in[11:8] <= 4'h0;
    endtask

    // input 10 registered then latched on global clock a; cell 0 transparent
    task in_modes;
        apb(1'b1, 11'h400, 32'h0012_8000);
        apb(1'b1, 11'h44A, 32'h2);
        drive.io_in[10] <= 1'b1;
        tick(6);
        `CHK(mc_pin[0], 1'b0)
        drive.global_clock_in[0] <= 1'b1;
        tick(6);
        `CHK(mc_pin[0], 1'b1)
        drive.global_clock_in[0] <= 1'b0;
        apb(1'b1, 11'h44A, 32'h1);
        drive.io_in[10] <= 1'b0;
        tick(6);
        `CHK(mc_pin[0], 1'b1)
        drive.global_clock_in[0] <= 1'b1;
        tick(6);
        `CHK(mc_pin[0], 1'b0)
        drive.global_clock_in[0] <= 1'b0;
        apb(1'b1, 11'h44A, 32'h0);
    endtask

    // master reset restarts configuration and reloads comparator 0 pattern
    task restart;
        apb(1'b1, 11'h464, 32'h0020_3F2A);
        drive.comparator_inputs <= 6'h2A;
        tick(5);
        `CHK(comparator_output[0], 1'b0)
        drive.master_reset_pin <= 1'b1;
        tick(5);
        apb(1'b0, 11'h467, 32'h0);
        `CHK(rd[0], 1'b1)
        drive.master_reset_pin <= 1'b0;
        tick(5);
        `CHK(comparator_output[0], 1'b1)
        while (rd[0] === 1'b1)
            apb(1'b0, 11'h467, 32'h0);
        `CHK(comparator_output[0], 1'b1)
    endtask

    task secure;
        apb(1'b0, 11'h468, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1'b0, 11'h000, 32'h0);
        `CHK({err, rd}, 33'h0_0000_0001)
        apb(1'b1, 11'h466, 32'h6);
        apb(1'b0, 11'h000, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1'b0, 11'h467, 32'h0);
        `CHK(rd[1:0], 2'b10)
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        drive = '0;
        drive.shared_output_enable = 1'b1;
        tick(5);
        presetn <= 1'b1;
        cfg_phase();
        alu_modes();
        ctrl_cell();
        in_modes();
        decode();
        compare();
        restart();
        secure();
        wrap_up();
    end
endmodule // tb_plm_fabric
